//--- design/temp_sensor_pkg.sv
/*
 * Shared constants of the temperature sensor register and alarm block:
 * register selects, configuration fields, reset values, bus framing and
 * conversion timing. Assumes a 125 MHz system clock.
 */
package temp_sensor_pkg;

	// ------------------------------------------------------------------
	// Clock and conversion timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int CONV_TIME_US = 100;
	localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------------
	// Register select codes in the pointer's two low bits
	// ------------------------------------------------------------------
	localparam logic [1:0] SEL_TEMP = 2'h0;
	localparam logic [1:0] SEL_CFG = 2'h1;
	localparam logic [1:0] SEL_HYST = 2'h2;
	localparam logic [1:0] SEL_TOS = 2'h3;

	// ------------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------------
	localparam int CFG_SHUTDOWN = 0;
	localparam int CFG_INT_MODE = 1;
	localparam int CFG_POLARITY = 2;
	localparam int CFG_FAULT_LO = 3;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;

	// Consecutive readings needed for fault settings 0..3
	localparam logic [2:0] FAULT_N0 = 3'h1;
	localparam logic [2:0] FAULT_N1 = 3'h2;
	localparam logic [2:0] FAULT_N2 = 3'h4;
	localparam logic [2:0] FAULT_N3 = 3'h6;

	// ------------------------------------------------------------------
	// Reset values; temperatures are 9-bit, 0.5 degree per step
	// ------------------------------------------------------------------
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [8:0] TOS_RESET = 9'h0A0;
	localparam logic [8:0] HYST_RESET = 9'h096;
	localparam logic [8:0] TEMP_RESET = 9'h000;

	// ------------------------------------------------------------------
	// Serial bus framing
	// ------------------------------------------------------------------
	localparam logic [3:0] BUS_ADDR_FIXED = 4'h9;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_ADDR = 8'h02,
		S_ADDR_ACK = 8'h04,
		S_WR_BYTE = 8'h08,
		S_WR_ACK = 8'h10,
		S_RD_BYTE = 8'h20,
		S_RD_ACK = 8'h40,
		S_IGNORE = 8'h80
	} bus_state_t;

endpackage

//--- design/sync_stage.sv
/*
 * Two flip-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs are slow levels; multi-bit groups must be static
 * or individually meaningful, as no coherence is given across bits.
 */
`timescale 1ns/10ps
module sync_stage #(
	parameter int WIDTH = 1
) (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta <= '1;
			sync_out <= '1;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // sync_stage

//--- design/temp_sensor_register_alarm.sv
/*
 * Register file, serial target interface and alarm logic of a digital
 * temperature sensor. Assumes a converter front end that presents a
 * 9-bit two's complement reading on temp_sample in the clock domain,
 * and an open-drain data line resolved outside from sda_oe_n.
 */
// Behaviour
// - The temperature register cannot be written by the host.
// - The temperature register loads only when a conversion ends.
// - A host read aborts conversion, which restarts after the read.
// - Temperatures are 9-bit two's complement, sent MSB first.
// - The hysteresis limit is readable and writable by the host.
// - Config is 8 bits: D7-D5 zero, fault D4-D3, pol, mode, shutdown.
// - The alarm runs in interrupt or comparator mode per config.
// - In interrupt mode any host read deasserts the alarm.
// - In comparator mode the alarm holds until temp is below hyst.
// - The alarm pin is active high or low per the polarity bit.
// - An 8-bit pointer's two low bits select the data register.
// - Three address pins let eight devices share the bus.
// - A limit must be crossed on N consecutive readings to act.
// - In comparator mode the alarm asserts when temp exceeds tos.
// - In interrupt mode, re-arm on hyst; shutdown clears the alarm.
`timescale 1ns/10ps
module temp_sensor_register_alarm
	import temp_sensor_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
) (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Serial bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Straps and converter
	input wire logic [2:0] bus_address_select,
	input wire logic [8:0] temp_sample,
	// Alarm
	output logic alarm_pin
);

	// ------------------------------------------------------------------
	// Input synchronisation and bus events
	// ------------------------------------------------------------------
	logic [4:0] sync_q;
	logic scl_s, sda_s, scl_d, sda_d;
	logic scl_rise, scl_fall, start_cond, stop_cond;

	sync_stage #(.WIDTH(5)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in({scl, sda_in, bus_address_select}),
		.sync_out(sync_q)
	);

	assign scl_s = sync_q[4];
	assign sda_s = sync_q[3];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_cond = scl_s && scl_d && sda_d && !sda_s;
	assign stop_cond = scl_s && scl_d && !sda_d && sda_s;

	// ------------------------------------------------------------------
	// Byte framing
	// ------------------------------------------------------------------
	bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in;
	logic byte_end, addr_match, is_read, read_hit, read_busy;
	logic [1:0] byte_idx;

	assign byte_end = scl_fall && bit_cnt == BITS_PER_BYTE;
	assign addr_match = shift_in[7:1] == {BUS_ADDR_FIXED, sync_q[2:0]};
	assign read_hit = state == S_ADDR && byte_end && addr_match && shift_in[0];
	assign read_busy = is_read &&
		(state == S_ADDR_ACK || state == S_RD_BYTE || state == S_RD_ACK);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= S_IDLE;
		end else if (start_cond) begin
			state <= S_ADDR;
		end else if (stop_cond) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_ADDR: if (byte_end) state <= addr_match ? S_ADDR_ACK : S_IGNORE;
				S_ADDR_ACK: if (scl_fall) state <= is_read ? S_RD_BYTE : S_WR_BYTE;
				S_WR_BYTE: if (byte_end) state <= S_WR_ACK;
				S_WR_ACK: if (scl_fall) state <= S_WR_BYTE;
				S_RD_BYTE: if (byte_end) state <= S_RD_ACK;
				// Host not-acknowledge ends the read
				S_RD_ACK: if (scl_fall) state <= shift_in[0] ? S_IGNORE : S_RD_BYTE;
				S_IDLE, S_IGNORE: state <= state;
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || start_cond) begin
			bit_cnt <= '0;
		end else if (scl_rise && (state == S_ADDR || state == S_WR_BYTE ||
				state == S_RD_BYTE)) begin
			bit_cnt <= bit_cnt + 4'h1;
		end else if (scl_fall && (state == S_ADDR_ACK || state == S_WR_ACK ||
				state == S_RD_ACK)) begin
			bit_cnt <= '0;
		end
	end

	// Bits arrive MSB first
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shift_in <= '0;
		end else if (scl_rise) begin
			shift_in <= {shift_in[6:0], sda_s};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			is_read <= 1'b0;
		end else if (state == S_ADDR && byte_end) begin
			is_read <= shift_in[0];
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [7:0] pointer;
	logic [7:0] cfg;
	logic [8:0] tos, hyst, temperature;
	logic [7:0] msb_hold;
	logic wr_end;

	assign wr_end = state == S_WR_BYTE && byte_end;

	always_ff @(posedge clock) begin
		if (sys_rst || start_cond) begin
			byte_idx <= '0;
		end else if (wr_end && byte_idx != 2'h2) begin
			byte_idx <= byte_idx + 2'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pointer <= POINTER_RESET;
			cfg <= CFG_RESET;
			tos <= TOS_RESET;
			hyst <= HYST_RESET;
			msb_hold <= '0;
		end else if (wr_end) begin
			if (byte_idx == 2'h0) begin
				pointer <= shift_in;
			end else if (byte_idx == 2'h1) begin
				msb_hold <= shift_in;
				if (pointer[1:0] == SEL_CFG) begin
					cfg <= shift_in & CFG_WRITE_MASK;
				end
			end else begin
				// Temperature selection falls through: writes are dropped
				case (pointer[1:0])
					SEL_TOS: tos <= {msb_hold, shift_in[7]};
					SEL_HYST: hyst <= {msb_hold, shift_in[7]};
					default: msb_hold <= msb_hold;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Conversion timing
	// ------------------------------------------------------------------
	logic [31:0] conv_cnt;
	logic conv_done;

	// Held at zero during a read so the next result is a whole conversion
	always_ff @(posedge clock) begin
		if (sys_rst || read_busy || cfg[CFG_SHUTDOWN]) begin
			conv_cnt <= '0;
			conv_done <= 1'b0;
		end else if (conv_cnt == 32'(CONV_LEN - 1)) begin
			conv_cnt <= '0;
			conv_done <= 1'b1;
		end else begin
			conv_cnt <= conv_cnt + 32'h1;
			conv_done <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			temperature <= TEMP_RESET;
		end else if (conv_done) begin
			temperature <= temp_sample;
		end
	end

	// ------------------------------------------------------------------
	// Read data and data line drive
	// ------------------------------------------------------------------
	logic rd_idx;
	logic [7:0] tx_shift, tx_byte;
	logic load_tx;
	logic [8:0] tx_word;

	always_comb begin
		case (pointer[1:0])
			SEL_TOS: tx_word = tos;
			SEL_HYST: tx_word = hyst;
			default: tx_word = temperature;
		endcase
		if (pointer[1:0] == SEL_CFG) begin
			tx_byte = cfg;
		end else if (rd_idx) begin
			tx_byte = {tx_word[0], 7'h00};
		end else begin
			tx_byte = tx_word[8:1];
		end
	end

	assign load_tx = scl_fall && ((state == S_ADDR_ACK && is_read) ||
		(state == S_RD_ACK && !shift_in[0]));

	always_ff @(posedge clock) begin
		if (sys_rst || start_cond) begin
			rd_idx <= 1'b0;
			tx_shift <= '0;
		end else if (load_tx) begin
			rd_idx <= !rd_idx;
			tx_shift <= {tx_byte[6:0], 1'b0};
		end else if (scl_fall && state == S_RD_BYTE) begin
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// Only ever pulls low; a high bit is a released line
	always_ff @(posedge clock) begin
		if (sys_rst || start_cond || stop_cond) begin
			sda_oe_n <= 1'b1;
		end else if (scl_fall) begin
			if (load_tx) begin
				sda_oe_n <= tx_byte[7];
			end else if (state == S_RD_BYTE && !byte_end) begin
				sda_oe_n <= tx_shift[7];
			end else if ((state == S_ADDR && byte_end && addr_match) ||
					wr_end) begin
				sda_oe_n <= 1'b0;
			end else begin
				sda_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		sda_out <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Alarm logic
	// ------------------------------------------------------------------
	logic hunt_low, alarm_active, shut_d;
	logic over, under, cond, alarm_event;
	logic [2:0] fault_cnt, fault_need;

	assign over = $signed(temp_sample) > $signed(tos);
	assign under = $signed(temp_sample) < $signed(hyst);
	assign cond = hunt_low ? under : over;

	always_comb begin
		case (cfg[CFG_FAULT_LO+:2])
			2'h0: fault_need = FAULT_N0;
			2'h1: fault_need = FAULT_N1;
			2'h2: fault_need = FAULT_N2;
			default: fault_need = FAULT_N3;
		endcase
	end

	assign alarm_event = conv_done && cond &&
		fault_cnt + 3'h1 >= fault_need;

	always_ff @(posedge clock) begin
		if (sys_rst || alarm_event || (conv_done && !cond)) begin
			fault_cnt <= '0;
		end else if (conv_done) begin
			fault_cnt <= fault_cnt + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shut_d <= 1'b0;
		end else begin
			shut_d <= cfg[CFG_SHUTDOWN];
		end
	end

	// Each event flips the hunt; comparator follows it, interrupt latches
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hunt_low <= 1'b0;
			alarm_active <= 1'b0;
		end else if (alarm_event) begin
			hunt_low <= !hunt_low;
			if (cfg[CFG_INT_MODE]) begin
				alarm_active <= 1'b1;
			end else begin
				alarm_active <= !hunt_low;
			end
		end else if (cfg[CFG_INT_MODE] && (read_hit ||
				(cfg[CFG_SHUTDOWN] && !shut_d))) begin
			alarm_active <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarm_pin <= 1'b1;
		end else begin
			alarm_pin <= cfg[CFG_POLARITY] ? alarm_active : !alarm_active;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	temp_only_conv_a: assert property (
		!$stable(temperature) |-> $past(conv_done))
		else $error("temperature changed without a conversion");

	temp_load_a: assert property (
		conv_done |=> temperature == $past(temp_sample))
		else $error("conversion result not loaded");

	read_abort_a: assert property (
		read_busy [*2] |-> conv_cnt == 0 && !conv_done)
		else $error("conversion ran during a read");

	cfg_top_zero_a: assert property (
		cfg[7:5] == 3'h0)
		else $error("configuration top bits not zero");

	int_read_clear_a: assert property (
		cfg[CFG_INT_MODE] && read_hit && !alarm_event |=> !alarm_active)
		else $error("interrupt alarm not cleared by read");

	cmp_hold_a: assert property (
		!cfg[CFG_INT_MODE] && alarm_active && !(conv_done && under)
		|=> alarm_active)
		else $error("comparator alarm dropped early");

	cmp_assert_a: assert property (
		!cfg[CFG_INT_MODE] && !hunt_low && alarm_event |=> ##1
		alarm_pin == cfg[CFG_POLARITY])
		else $error("comparator alarm not raised on overtemperature");

	pin_polarity_a: assert property (
		$stable(cfg) && $stable(alarm_active) |->
		alarm_pin == (cfg[CFG_POLARITY] ~^ alarm_active))
		else $error("alarm pin polarity wrong");

	shutdown_halt_a: assert property (
		cfg[CFG_SHUTDOWN] |=> conv_cnt == 0 && !conv_done)
		else $error("conversion ran in shutdown");

	fault_need_a: assert property (
		conv_done && cond && fault_cnt + 3'h1 < fault_need |=> !$changed(hunt_low))
		else $error("alarm moved before fault count reached");

	foreign_quiet_a: assert property (
		state == S_IGNORE && $past(state == S_IGNORE) |-> sda_oe_n)
		else $error("data line driven for a foreign address");

	conv_seen_c: cover property (conv_done ##1 temperature != TEMP_RESET);
	read_seen_c: cover property (read_hit ##[1:1000] stop_cond);
	alarm_rise_c: cover property (!alarm_active ##1 alarm_active);
	cfg_write_c: cover property (wr_end && pointer[1:0] == SEL_CFG);

endmodule // temp_sensor_register_alarm

//--- bench/i2c_host_model.sv
/*
 * Behavioural two-wire bus host: drives the bus clock and pulls the data
 * line low. Assumes an external pull-up resolves the data wire.
 */
`timescale 1ns/10ps
module i2c_host_model (
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda_wire
);
	// ------------------------------------------------------------------
	// Bus timing
	// ------------------------------------------------------------------
	// 125 ns bus clock; it stands high between frames
	localparam realtime HALF = 62.5;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ------------------------------------------------------------------
	// Bus primitives
	// ------------------------------------------------------------------
	task automatic bus_start();
		sda_low = 1'b0;
		#(HALF);
		scl = 1'b1;
		#(HALF);
		sda_low = 1'b1;
		#(HALF);
		scl = 1'b0;
		#(HALF / 4);
	endtask

	// Data moves a quarter phase after the fall, well clear of the rise
	task automatic bus_bit(input logic b, output logic r);
		sda_low = ~b;
		#(HALF * 3 / 4);
		scl = 1'b1;
		#(HALF / 2);
		r = sda_wire;
		#(HALF / 2);
		scl = 1'b0;
		#(HALF / 4);
	endtask

	task automatic bus_stop();
		sda_low = 1'b1;
		#(HALF);
		scl = 1'b1;
		#(HALF);
		sda_low = 1'b0;
		#(HALF);
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(d[i], r);
		end
		bus_bit(1'b1, r);
		ack = ~r;
	endtask

	task automatic recv_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(1'b1, d[i]);
		end
		bus_bit(~more, r);
	endtask
endmodule // i2c_host_model

//--- bench/tb.sv
/*
 * Self-checking bench for the sensor register and alarm block.
 * Assumes the bus host model and a pulled-up open-drain data wire.
 */
`timescale 1ns/10ps
module tb
	import temp_sensor_pkg::*;
();
	localparam int CONV = 50;
	logic clock;
	logic sys_rst;
	logic scl;
	logic host_low;
	logic sda_out;
	logic sda_oe_n;
	logic sda_wire;
	logic [2:0] strap;
	logic [8:0] temp_sample;
	logic alarm_pin;
	logic ack;
	logic [15:0] rv;
	int bad_count = 0;
	int total_checks = 0;

	assign sda_wire = !(host_low || (!sda_oe_n && !sda_out));

	temp_sensor_register_alarm #(.CONV_LEN(CONV)) u_dut (
		.clock(clock), .sys_rst(sys_rst),
		.scl(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.bus_address_select(strap), .temp_sample(temp_sample),
		.alarm_pin(alarm_pin)
	);

	i2c_host_model u_host (
		.scl(scl), .sda_low(host_low), .sda_wire(sda_wire)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic finish_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic chk_al(input logic e);
		check({15'h0000, alarm_pin}, {15'h0000, e});
	endtask

	task automatic step(input logic [8:0] t, input int n, input logic e);
		@(negedge clock);
		temp_sample = t;
		cyc(n * CONV + 10);
		chk_al(e);
	endtask

	task automatic wr(input int p, input int n, input logic [15:0] d);
		u_host.bus_start();
		u_host.send_byte({BUS_ADDR_FIXED, strap, 1'b0}, ack);
		u_host.send_byte(8'(p), ack);
		if (n > 0) u_host.send_byte(d[15:8], ack);
		if (n > 1) u_host.send_byte(d[7:0], ack);
		u_host.bus_stop();
	endtask

	// A negative pointer keeps the one already set
	task automatic rd(input int p, input int n, output logic [15:0] d);
		logic [7:0] b;
		if (p >= 0) wr(8'(p), 0, 16'h0000);
		u_host.bus_start();
		u_host.send_byte({BUS_ADDR_FIXED, strap, 1'b1}, ack);
		for (int k = 0; k < n; k++) begin
			u_host.recv_byte(k < n - 1, b);
			d = {d[7:0], b};
		end
		u_host.bus_stop();
	endtask

	initial begin
		#400000;
		bad_count++;
		finish_test();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		strap = 3'h5;
		temp_sample = 9'h032;
		cyc(20);
		sys_rst = 1'b0;
		cyc(3 * CONV);
		chk_al(1'b1);
		rd(-1, 2, rv);
		check(rv, {9'h032, 7'h00});
		rd(1, 2, rv);
		check(rv, 16'h0000);
		rd(3, 2, rv);
		check(rv, {9'h0A0, 7'h00});
		rd(2, 2, rv);
		check(rv, {9'h096, 7'h00});
		wr(2, 2, {9'h1FF, 7'h00});
		rd(2, 2, rv);
		check(rv, 16'hFF80);
		wr(8'hFB, 2, 16'h3280);
		rd(3, 2, rv);
		check(rv, 16'h3280);
		wr(0, 2, 16'h7F80);
		rd(0, 2, rv);
		check(rv, {9'h032, 7'h00});
		wr(1, 1, 16'hFF00);
		rd(1, 2, rv);
		check(rv, 16'h1F1F);
		// Shutdown freezes the reading but not the registers
		step(9'h040, 3, 1'b0);
		// No conversion can hide a landed write while shut down
		wr(0, 2, 16'h7F80);
		rd(0, 2, rv);
		check(rv, {9'h032, 7'h00});
		wr(1, 1, 16'h0000);
		cyc(3 * CONV);
		rd(0, 2, rv);
		check(rv, {9'h040, 7'h00});
		// Comparator with tos 50.5 and hyst 40 degrees
		wr(2, 2, 16'h2800);
		step(9'h070, 3, 1'b0);
		step(9'h058, 3, 1'b0);
		step(9'h1CE, 3, 1'b1);
		wr(1, 1, 16'h0400);
		step(9'h1CE, 1, 1'b0);
		step(9'h070, 3, 1'b1);
		step(9'h1CE, 3, 1'b0);
		// Six readings needed: four is too few, eight is enough
		wr(1, 1, 16'h1800);
		step(9'h1CE, 8, 1'b1);
		step(9'h070, 4, 1'b1);
		step(9'h070, 4, 1'b0);
		step(9'h1CE, 8, 1'b1);
		// Interrupt mode from a fresh reset
		sys_rst = 1'b1;
		cyc(20);
		sys_rst = 1'b0;
		cyc(3);
		wr(1, 1, 16'h0200);
		step(9'h0B0, 3, 1'b0);
		rd(1, 2, rv);
		step(9'h0B0, 3, 1'b1);
		step(9'h1CE, 3, 1'b0);
		rd(2, 2, rv);
		check(rv, {9'h096, 7'h00});
		step(9'h1CE, 3, 1'b1);
		step(9'h0B0, 3, 1'b0);
		wr(1, 1, 16'h0300);
		cyc(5);
		chk_al(1'b1);
		// A long read holds off conversion until it ends
		wr(1, 1, 16'h0000);
		step(9'h020, 3, 1'b1);
		wr(0, 0, 16'h0000);
		fork
			rd(-1, 4, rv);
			begin
				cyc(300);
				temp_sample = 9'h030;
			end
		join
		check(rv, {9'h020, 7'h00});
		cyc(3 * CONV);
		rd(-1, 2, rv);
		check(rv, {9'h030, 7'h00});
		// Every strap setting answers its own address and not the complemented one
		for (int s = 0; s < 8; s++) begin
			@(negedge clock);
			strap = 3'(s);
			cyc(4);
			u_host.bus_start();
			u_host.send_byte({BUS_ADDR_FIXED, strap, 1'b0}, ack);
			u_host.bus_stop();
			check({15'h0000, ack}, 16'h0001);
			u_host.bus_start();
			u_host.send_byte({BUS_ADDR_FIXED, ~strap, 1'b0}, ack);
			u_host.bus_stop();
			check({15'h0000, ack}, 16'h0000);
		end
		finish_test();
	end
endmodule // tb
